// ==== inc/vic_pkg.sv ====
// package: constants and types for the vectored interrupt controller block
`default_nettype none
package vic_pkg;
    localparam int unsigned NUM_SRC    = 32;
    localparam int unsigned PRIO_W     = 3;
    localparam int unsigned SRC_W      = 5;
    localparam int unsigned VEC_W      = 32;
    // peripheral identifiers
    localparam logic [4:0]  ID_FAST    = 5'h00;
    localparam logic [4:0]  ID_SYS     = 5'h01;
    localparam logic [4:0]  ID_CONV    = 5'h05;
    localparam logic [4:0]  ID_USBH    = 5'h14;
    localparam logic [4:0]  ID_EXT0    = 5'h1D;
    localparam logic [4:0]  ID_EXT2    = 5'h1F;
    // identifiers whose clock enables are writable
    localparam logic [31:0] CLK_GATEABLE = 32'h1FEF_FFDC;
    // identifiers of the fast input and external lines
    localparam logic [31:0] EXT_SRC_MASK = 32'hE000_0001;
    // reset values and nesting stack depth
    localparam logic [31:0] MASK_RST   = 32'h0000_0000;
    localparam logic [31:0] MODE_RST   = 32'h0000_0000;
    localparam logic [31:0] CLK_EN_RST = 32'h0000_0000;
    localparam logic [2:0]  PRIO_RST   = 3'h0;
    localparam logic [4:0]  NONE_SRC   = 5'h00;
    localparam logic [3:0]  STACK_DEPTH = 4'h8;
    typedef enum logic [2:0] {
        VIC_IDLE  = 3'b001,
        VIC_SERVE = 3'b010,
        VIC_DONE  = 3'b100
    } vic_svc_t;
endpackage : vic_pkg
`default_nettype wire

// ==== src/vic_vec_mem.sv ====
// vector memory: one 32-bit vector per source, registered read data
`timescale 1ns/1ps
`default_nettype none
module vic_vec_mem (
    // clock input
    input  wire logic        ref_clk_i,
    // write port
    input  wire logic        wr_en_i,
    input  wire logic [4:0]  wr_idx_i,
    input  wire logic [31:0] wr_data_i,
    // read port
    input  wire logic [4:0]  rd_idx_i,
    output logic      [31:0] rd_data_o
);
    logic [31:0] mem_q [32];

    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_idx_i] <= wr_data_i;
        end
        rd_data_o <= mem_q[rd_idx_i];
    end
endmodule : vic_vec_mem
`default_nettype wire

// ==== src/vic_clk_map.sv ====
// peripheral clock-enable map: set/clear writes and converter auto clock
`timescale 1ns/1ps
`default_nettype none
module vic_clk_map (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    // set and clear strobes, one bit per identifier
    input  wire logic [31:0] clk_set_i,
    input  wire logic [31:0] clk_clr_i,
    // converter handshake
    input  wire logic        conv_start_i,
    input  wire logic        conv_done_i,
    input  wire logic        conv_sleep_i,
    // outputs
    output logic      [31:0] clk_en_o,
    output logic             conv_clk_o
);
    logic [31:0] en_d;
    logic        conv_d;

    // only gateable identifiers take set/clear
    assign en_d = (clk_en_o | (clk_set_i & vic_pkg::CLK_GATEABLE))
                & ~(clk_clr_i & vic_pkg::CLK_GATEABLE); // RULE15 RULE16 RULE18

    // converter clock starts on conversion, stops after it in sleep mode
    assign conv_d = conv_start_i ? 1'b1 :
                    (conv_done_i && conv_sleep_i) ? 1'b0 : conv_clk_o; // RULE17

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            clk_en_o   <= vic_pkg::CLK_EN_RST;
            conv_clk_o <= 1'b0;
        end else begin
            clk_en_o   <= en_d;
            conv_clk_o <= conv_d;
        end
    end
endmodule : vic_clk_map
`default_nettype wire

// ==== src/vic_top.sv ====
// vectored interrupt controller with peripheral identifier clock map
// Operation
// (RULE1) drive active-low normal and fast requests from prioritised and forced sources
// (RULE2) thirty-two sources, each individually maskable with its own vector
// (RULE3) source 0 goes only to fast line, outside priority scheme
// (RULE4) source 1 is OR of eight system block interrupts
// (RULE5) edge or level per source; external lines also pick polarity
// (RULE6) three external lines plus the external fast input
// (RULE7) eight-level priority over sources 1..31 drives normal request
// (RULE8) higher-priority pending source re-asserts request during service
// (RULE9) one 32-bit vector per source; vector read returns current one
// (RULE10) protect mode stops vector reads from changing state
// (RULE11) fast forcing moves any normal source onto fast line
// (RULE12) identifiers 2..16: io, converter, serial, card, usb, bus, spi
// (RULE13) identifiers 17..28: timers, usb host, mac, sensor, serial, bus
// (RULE14) fast input is identifier 0, external lines are 29..31
// (RULE15) external line identifiers have no clock gating
// (RULE16) set/clear of clocks for fixed identifiers does nothing
// (RULE17) converter clock starts on conversion, stops after it in sleep
// (RULE18) system peripherals never gated; identifier 1 only for interrupts
// (RULE19) source 1 is always level-sensitive
`timescale 1ns/1ps
`default_nettype none
module vic_top (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    // external pins (asynchronous)
    input  wire logic        fast_interrupt_input_i,
    input  wire logic        external_irq_line_0_i,
    input  wire logic        external_irq_line_1_i,
    input  wire logic        external_irq_line_2_i,
    // system block interrupts feeding source 1
    input  wire logic        sdram_irq_i,
    input  wire logic        debug_serial_unit_irq_i,
    input  wire logic        periodic_interval_timer_irq_i,
    input  wire logic        real_time_timer_irq_i,
    input  wire logic        watchdog_irq_i,
    input  wire logic        reset_ctrl_irq_i,
    input  wire logic        power_clock_manager_irq_i,
    input  wire logic        flash_controller_irq_i,
    // on-chip peripheral interrupts, bit index is identifier
    input  wire logic [31:0] periph_irq_i,
    // configuration
    input  wire logic [31:0] src_mask_i,
    input  wire logic [31:0] src_edge_i,
    input  wire logic [31:0] src_pol_i,
    input  wire logic [31:0] fast_force_i,
    input  wire logic [95:0] src_prio_i,
    input  wire logic        protect_i,
    // vector programming
    input  wire logic        vec_wr_i,
    input  wire logic [4:0]  vec_wr_idx_i,
    input  wire logic [31:0] vec_wr_data_i,
    // service handshake
    input  wire logic        vec_rd_i,
    input  wire logic        eoi_i,
    input  wire logic        fast_ack_i,
    // clock map
    input  wire logic [31:0] clk_set_i,
    input  wire logic [31:0] clk_clr_i,
    input  wire logic        conv_start_i,
    input  wire logic        conv_done_i,
    input  wire logic        conv_sleep_i,
    // processor lines
    output logic             normal_irq_request_n_o,
    output logic             fast_irq_request_n_o,
    // status
    output logic      [31:0] vec_data_o,
    output logic      [4:0]  cur_src_o,
    output logic      [31:0] pending_o,
    output logic      [31:0] clk_en_o,
    output logic             conv_clk_o
);
    // pin synchronisers
    logic [3:0]  pin_s1_q;
    logic [3:0]  pin_s2_q;
    // level history for edge detect
    logic [31:0] lvl_prev_q;
    logic [31:0] pend_q;
    logic [31:0] pend_d;
    // nesting stack of priorities and sources
    logic [2:0]  stk_prio_q [8];
    logic [4:0]  stk_src_q  [8];
    logic [3:0]  depth_q;
    logic [3:0]  depth_d;
    logic [4:0]  cur_q;
    vic_pkg::vic_svc_t svc_q;
    vic_pkg::vic_svc_t svc_d;

    function automatic logic [2:0] prio_of(input logic [95:0] p,
                                           input logic [4:0] s);
        prio_of = p[s*3 +: 3];
    endfunction : prio_of

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pin_s1_q <= 4'h0;
        end else begin
            pin_s1_q <= {external_irq_line_2_i, external_irq_line_1_i,
                         external_irq_line_0_i, fast_interrupt_input_i}; // RULE6
        end
    end

    // only the second stage is read by logic
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pin_s2_q <= 4'h0;
        end else begin
            pin_s2_q <= pin_s1_q;
        end
    end

    // raw source vector, index is identifier
    wire [7:0]  sys_lines = {sdram_irq_i, debug_serial_unit_irq_i,
                             periodic_interval_timer_irq_i,
                             real_time_timer_irq_i, watchdog_irq_i,
                             reset_ctrl_irq_i, power_clock_manager_irq_i,
                             flash_controller_irq_i};
    wire        sys_or    = |sys_lines; // RULE4
    wire [31:0] raw_src = {pin_s2_q[3:1], periph_irq_i[28:2], sys_or,
                           pin_s2_q[0]}; // RULE12 RULE13 RULE14
    // polarity applies to the fast input and external lines only, internal are active high
    wire [31:0] pol_inv = src_pol_i & vic_pkg::EXT_SRC_MASK;
    wire [31:0] act_lvl = raw_src ^ pol_inv; // RULE5
    // source 1 never edge
    wire [31:0] is_edge = src_edge_i & ~32'h0000_0002; // RULE19
    wire [31:0] rise    = act_lvl & ~lvl_prev_q;

    // service events clear an edge-pending bit
    wire        vec_take  = vec_rd_i && !protect_i; // RULE10
    wire        fast_take = fast_ack_i && !protect_i; // RULE10
    logic [31:0] clr_edge;
    logic [4:0]  best_src;
    logic [2:0]  best_prio;
    logic        best_ok;

    wire [31:0] pend_vis = pend_q & src_mask_i; // RULE2
    wire [31:0] norm_set = pend_vis & ~fast_force_i & ~32'h0000_0001; // RULE3
    wire [31:0] fast_set = pend_vis & (fast_force_i | 32'h0000_0001); // RULE11

    // highest priority pending normal source; lower index wins ties
    always_comb begin
        best_src  = vic_pkg::NONE_SRC;
        best_prio = vic_pkg::PRIO_RST;
        best_ok   = 1'b0;
        for (int i = 31; i >= 1; i--) begin
            if (norm_set[i] &&
                (!best_ok || prio_of(src_prio_i, 5'(i)) >= best_prio)) begin
                best_src  = 5'(i);
                best_prio = prio_of(src_prio_i, 5'(i));
                best_ok   = 1'b1;
            end
        end
    end // RULE7

    wire [2:0] top_prio = stk_prio_q[3'(depth_q - 4'h1)];
    // nests only above the priority now in service
    wire       above_top = depth_q == 4'h0 || best_prio > top_prio; // RULE8
    wire       nest_room = depth_q < vic_pkg::STACK_DEPTH;
    wire       req_norm  = best_ok && above_top && nest_room; // RULE7 RULE8
    wire       push     = vec_take && req_norm;
    wire       pop      = eoi_i && depth_q != 4'h0 && !protect_i;

    // a push retires the served edge, a fast ack the fast-routed edges
    always_comb begin
        clr_edge = 32'h0000_0000;
        if (push) begin
            clr_edge[best_src] = 1'b1;
        end
        if (fast_take) begin
            clr_edge = clr_edge | (fast_set & is_edge);
        end
    end

    // set wins over clear; level sources follow the line
    wire [31:0] edge_keep = pend_q & ~clr_edge;
    wire [31:0] edge_pend = is_edge & (edge_keep | rise);
    wire [31:0] lvl_pend  = ~is_edge & act_lvl;
    assign pend_d = edge_pend | lvl_pend; // RULE5
    // depth counts nested services, eight at most
    assign depth_d = push ? depth_q + 4'h1 : pop ? depth_q - 4'h1 : depth_q;

    always_comb begin
        svc_d = svc_q;
        unique case (svc_q)
            vic_pkg::VIC_IDLE:  if (push) svc_d = vic_pkg::VIC_SERVE;
            vic_pkg::VIC_SERVE: if (pop && depth_q == 4'h1)
                                    svc_d = vic_pkg::VIC_DONE;
            vic_pkg::VIC_DONE:  svc_d = push ? vic_pkg::VIC_SERVE
                                             : vic_pkg::VIC_IDLE;
            default:            svc_d = vic_pkg::VIC_IDLE;
        endcase
    end

    // follows the live level through reset, so no false edge comes after
    always_ff @(posedge ref_clk_i) begin
        lvl_prev_q <= act_lvl;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pend_q <= 32'h0000_0000;
        end else begin
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            depth_q <= 4'h0;
        end else begin
            depth_q <= depth_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            svc_q <= vic_pkg::VIC_IDLE;
        end else begin
            svc_q <= svc_d;
        end
    end

    // one slot per nesting level holds priority and source
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            for (int k = 0; k < 8; k++) begin
                stk_prio_q[k] <= vic_pkg::PRIO_RST;
                stk_src_q[k]  <= vic_pkg::NONE_SRC;
            end
        end else if (push) begin
            stk_prio_q[depth_q[2:0]] <= best_prio;
            stk_src_q[depth_q[2:0]]  <= best_src;
        end
    end

    // on the last pop the controller returns to no source in service
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cur_q <= vic_pkg::NONE_SRC;
        end else if (push) begin
            cur_q <= best_src;
        end else if (pop) begin
            cur_q <= (depth_q == 4'h1) ? vic_pkg::NONE_SRC
                                       : stk_src_q[3'(depth_q - 4'h2)];
        end
    end

    // outputs from flip-flops, active low requests
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            normal_irq_request_n_o <= 1'b1;
        end else begin
            normal_irq_request_n_o <= !req_norm; // RULE1
        end
    end

    // source 0 and forced sources share the fast line
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            fast_irq_request_n_o <= 1'b1;
        end else begin
            fast_irq_request_n_o <= !(|fast_set); // RULE1 RULE11
        end
    end

    // pending shows raw state, the mask acts on requests only
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pending_o <= 32'h0000_0000;
        end else begin
            pending_o <= pend_q;
        end
    end
    assign cur_src_o = cur_q;

    // vector read returns the vector of the source being selected
    wire [4:0] vec_idx = req_norm ? best_src : cur_q; // RULE9

    vic_vec_mem u_vec (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (vec_wr_i),
        .wr_idx_i  (vec_wr_idx_i),
        .wr_data_i (vec_wr_data_i),
        .rd_idx_i  (vec_idx),
        .rd_data_o (vec_data_o)
    );

    vic_clk_map u_clk (
        .ref_clk_i    (ref_clk_i),
        .sys_rst_i    (sys_rst_i),
        .clk_set_i    (clk_set_i),
        .clk_clr_i    (clk_clr_i),
        .conv_start_i (conv_start_i),
        .conv_done_i  (conv_done_i),
        .conv_sleep_i (conv_sleep_i),
        .clk_en_o     (clk_en_o),
        .conv_clk_o   (conv_clk_o)
    );
endmodule : vic_top
`default_nettype wire

// ==== sim/vic_top_assertions.sv ====
// checker: port-level properties of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_checker (
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        sys_rst_i,
    // watched inputs
    input wire logic        sdram_irq_i,
    input wire logic [31:0] src_mask_i,
    input wire logic        protect_i,
    input wire logic        vec_rd_i,
    input wire logic        conv_start_i,
    input wire logic        conv_done_i,
    input wire logic        conv_sleep_i,
    // watched outputs
    input wire logic        normal_irq_request_n_o,
    input wire logic        fast_irq_request_n_o,
    input wire logic [4:0]  cur_src_o,
    input wire logic [31:0] pending_o,
    input wire logic [31:0] clk_en_o,
    input wire logic        conv_clk_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    a_reset_idle: assert property ($fell(sys_rst_i) |->
        normal_irq_request_n_o && fast_irq_request_n_o && cur_src_o == 5'h00)
        else $error("lines not idle after reset");
    a_idle_quiet: assert property (pending_o == 32'h0 [*3] |->
        normal_irq_request_n_o && fast_irq_request_n_o)
        else $error("request without pending source");
    a_sys_level: assert property ((sdram_irq_i && src_mask_i[1]) [*3] |->
        pending_o[1]) else $error("system source not pending");
    a_clk_fixed: assert property (
        (clk_en_o & ~vic_pkg::CLK_GATEABLE) == 32'h0)
        else $error("fixed identifier clock enabled");
    a_push_moves: assert property (
        vec_rd_i && !protect_i && !normal_irq_request_n_o |=>
        cur_src_o != $past(cur_src_o)) else $error("ack did not nest");
    a_prot_hold: assert property (protect_i |=> $stable(cur_src_o))
        else $error("service state moved under protect");
    a_conv_start: assert property (conv_start_i |=> conv_clk_o)
        else $error("converter clock not started");
    a_conv_stop: assert property (
        conv_done_i && conv_sleep_i && !conv_start_i |=> !conv_clk_o)
        else $error("converter clock not stopped");
endmodule : vic_checker
bind vic_top vic_checker u_chk (.*);
`default_nettype wire

// ==== sim/vic_cpu_model.sv ====
// processor model: acknowledges normal requests, ends service later
`timescale 1ns/1ps
`default_nettype none
module vic_cpu_model (
    // clock and control
    input  wire logic       ref_clk_i,
    input  wire logic       en_i,
    input  wire logic [3:0] hold_i,
    // controller lines
    input  wire logic       normal_irq_request_n_i,
    output logic            vec_rd_o,
    output logic            eoi_o
);
    logic [3:0] cnt;
    logic       busy = 1'b0;
    initial vec_rd_o = 1'b0;
    initial eoi_o = 1'b0;
    // pulses change after the falling edge, held one full cycle
    always @(negedge ref_clk_i) begin
        vec_rd_o <= !busy && en_i && !normal_irq_request_n_i;
        eoi_o <= busy && cnt == 4'h0;
        if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end else if (en_i && !normal_irq_request_n_i) begin
            busy <= 1'b1;
            cnt <= hold_i;
        end
    end
endmodule : vic_cpu_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// testbench: drives the interrupt controller and checks its ports
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk_i, sys_rst_i, protect_i, vec_wr_i, eoi_i, fast_ack_i;
    logic fast_interrupt_input_i, external_irq_line_0_i;
    logic external_irq_line_1_i, external_irq_line_2_i;
    logic sdram_irq_i, debug_serial_unit_irq_i, watchdog_irq_i;
    logic periodic_interval_timer_irq_i, real_time_timer_irq_i;
    logic reset_ctrl_irq_i, power_clock_manager_irq_i;
    logic flash_controller_irq_i, conv_start_i, conv_done_i, conv_sleep_i;
    logic vec_rd_i, tb_rd, tb_eoi, m_rd, m_eoi, m_en, conv_clk_o;
    logic normal_irq_request_n_o, fast_irq_request_n_o;
    logic [31:0] periph_irq_i, src_mask_i, src_edge_i, src_pol_i;
    logic [31:0] fast_force_i, vec_wr_data_i, clk_set_i, clk_clr_i;
    logic [31:0] vec_data_o, pending_o, clk_en_o;
    logic [95:0] src_prio_i;
    logic [4:0]  vec_wr_idx_i, cur_src_o;
    logic [7:0]  sys_v;
    int          miscompares, n_checks, cyc;
    assign {sdram_irq_i, debug_serial_unit_irq_i, watchdog_irq_i,
            periodic_interval_timer_irq_i, real_time_timer_irq_i,
            reset_ctrl_irq_i, power_clock_manager_irq_i,
            flash_controller_irq_i} = sys_v;
    assign vec_rd_i = tb_rd | m_rd;
    assign eoi_i = tb_eoi | m_eoi;
    vic_top dut (.*);
    vic_cpu_model u_cpu (.ref_clk_i(ref_clk_i), .en_i(m_en), .hold_i(4'h4),
        .normal_irq_request_n_i(normal_irq_request_n_o),
        .vec_rd_o(m_rd), .eoi_o(m_eoi));
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic ok);
        n_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t port value differs", $time);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : wt
    // one-cycle acknowledge (e=0) or end of service (e=1)
    task automatic pls(input bit e);
        tb_rd = !e;
        tb_eoi = e;
        wt(1);
        tb_rd = 1'b0;
        tb_eoi = 1'b0;
        wt(1);
    endtask : pls
    task automatic t_prio();
        src_prio_i[15+:3] = 3'h2;
        src_prio_i[27+:3] = 3'h5;
        periph_irq_i[5] = 1'b1;
        wt(3);
        chk(normal_irq_request_n_o === 1'b0);
        chk(vec_data_o === 32'hA000_0005);
        pls(1'b0);
        chk(cur_src_o === 5'h05);
        periph_irq_i[9] = 1'b1;
        wt(3);
        chk(normal_irq_request_n_o === 1'b0);
        chk(vec_data_o === 32'hA000_0009);
        pls(1'b0);
        chk(cur_src_o === 5'h09);
        periph_irq_i = 32'h0;
        pls(1'b1);
        chk(cur_src_o === 5'h05);
        pls(1'b1);
        chk(cur_src_o === 5'h00);
    endtask : t_prio
    task automatic t_prot();
        protect_i = 1'b1;
        periph_irq_i[5] = 1'b1;
        wt(3);
        pls(1'b0);
        chk(cur_src_o === 5'h00);
        protect_i = 1'b0;
        m_en = 1'b1;
        wt(4);
        chk(cur_src_o === 5'h05);
        m_en = 1'b0;
        periph_irq_i[5] = 1'b0;
        wt(8);
        chk(cur_src_o === 5'h00);
    endtask : t_prot
    task automatic t_force();
        fast_force_i[9] = 1'b1;
        periph_irq_i[9] = 1'b1;
        wt(3);
        chk(fast_irq_request_n_o === 1'b0);
        chk(normal_irq_request_n_o === 1'b1);
        src_mask_i[9] = 1'b0;
        wt(3);
        chk(fast_irq_request_n_o === 1'b1);
        src_mask_i[9] = 1'b1;
        src_edge_i[9] = 1'b1;
        periph_irq_i[9] = 1'b0;
        wt(1);
        fast_ack_i = 1'b1;
        wt(1);
        fast_ack_i = 1'b0;
        wt(2);
        chk(fast_irq_request_n_o === 1'b1);
        chk(pending_o[9] === 1'b0);
        fast_force_i[9] = 1'b0;
        src_edge_i[9] = 1'b0;
        wt(3);
    endtask : t_force
    task automatic t_pins();
        src_pol_i = 32'hE000_0001;
        wt(6);
        chk((pending_o & 32'hE000_0001) === 32'hE000_0001);
        chk(fast_irq_request_n_o === 1'b0);
        src_pol_i = 32'h0;
        wt(6);
        chk((pending_o & 32'hE000_0001) === 32'h0);
        fast_interrupt_input_i = 1'b1;
        external_irq_line_1_i = 1'b1;
        wt(5);
        chk(pending_o[31:29] === 3'h2 && pending_o[0] === 1'b1);
        chk(fast_irq_request_n_o === 1'b0);
        fast_interrupt_input_i = 1'b0;
        external_irq_line_1_i = 1'b0;
        wt(5);
        chk((pending_o & 32'hE000_0001) === 32'h0);
        src_edge_i[9] = 1'b1;
        periph_irq_i[9] = 1'b1;
        wt(1);
        periph_irq_i[9] = 1'b0;
        wt(4);
        chk(pending_o[9] === 1'b1);
        pls(1'b0);
        wt(2);
        chk(pending_o[9] === 1'b0);
        pls(1'b1);
        src_edge_i = 32'h0;
    endtask : t_pins
    task automatic t_sys();
        src_edge_i[1] = 1'b1;
        for (int i = 0; i < 8; i++) begin
            sys_v = 8'h01 << i;
            wt(3);
            chk(pending_o[1] === 1'b1);
            sys_v = 8'h00;
            wt(3);
            chk(pending_o[1] === 1'b0);
        end
        src_edge_i[1] = 1'b0;
    endtask : t_sys
    task automatic t_clk();
        clk_set_i = 32'hFFFF_FFFF;
        conv_start_i = 1'b1;
        wt(1);
        clk_set_i = 32'h0;
        conv_start_i = 1'b0;
        conv_done_i = 1'b1;
        wt(1);
        chk(clk_en_o === 32'h1FEF_FFDC);
        chk(conv_clk_o === 1'b1);
        clk_clr_i = 32'hFFFF_FFFF;
        conv_sleep_i = 1'b1;
        wt(1);
        chk(clk_en_o === 32'h0);
        chk(conv_clk_o === 1'b0);
    endtask : t_clk
    initial begin
        {sys_rst_i, m_en, protect_i, tb_rd, tb_eoi, fast_ack_i} = 6'h20;
        {fast_interrupt_input_i, external_irq_line_0_i} = 2'h0;
        {external_irq_line_1_i, external_irq_line_2_i, sys_v} = 10'h000;
        {conv_start_i, conv_done_i, conv_sleep_i, vec_wr_i} = 4'h0;
        {periph_irq_i, src_edge_i, src_pol_i, fast_force_i} = 128'h0;
        {clk_set_i, clk_clr_i, vec_wr_data_i} = 96'h0;
        src_mask_i = 32'hFFFF_FFFF;
        src_prio_i = 96'h0;
        vec_wr_idx_i = 5'h00;
        wt(4);
        sys_rst_i = 1'b0;
        chk({normal_irq_request_n_o, fast_irq_request_n_o} === 2'h3);
        chk({pending_o, clk_en_o, cur_src_o} === 69'h0);
        for (int i = 0; i < 32; i++) begin
            vec_wr_i = 1'b1;
            vec_wr_idx_i = i[4:0];
            vec_wr_data_i = 32'hA000_0000 | 32'(i);
            wt(1);
        end
        vec_wr_i = 1'b0;
        t_prio();
        t_prot();
        t_force();
        t_pins();
        t_sys();
        t_clk();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
